// file: include/pwmtdc_pkg.sv
// Purpose: Constants for the PWM timer block (register map, codes, timing).
// Assumes: AXI4-Lite, 32-bit data, 16-bit counter.
// Notes: Offsets are byte addresses.
package pwmtdc_pkg;
   localparam int CNT_W = 16;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_ACTION = 8'h04;
   localparam logic [7:0] OFF_DUTY_A = 8'h08;
   localparam logic [7:0] OFF_PERIOD_B = 8'h0C;
   localparam logic [7:0] OFF_BUF_C = 8'h10;
   localparam logic [7:0] OFF_RWE_A = 8'h14;
   localparam logic [7:0] OFF_RWE_B = 8'h18;
   localparam logic [7:0] OFF_CDUTY_U = 8'h1C;
   localparam logic [7:0] OFF_CDUTY_V = 8'h20;
   localparam logic [7:0] OFF_CDUTY_W = 8'h24;
   localparam logic [7:0] OFF_DEAD = 8'h28;
   localparam logic [7:0] OFF_STATUS = 8'h2C;
   localparam logic [7:0] OFF_COUNT = 8'h30;
   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   localparam int CTRL_RUN = 0;
   localparam int CTRL_BUF_EN = 1;
   localparam int CTRL_COMP = 2;
   localparam int CTRL_PINSEL = 3;
   localparam int CTRL_LOCKED = 4;
   localparam int ACT_A_LSB = 0;
   localparam int ACT_B_LSB = 4;
   localparam int RWE_BIT = 0;
   // ----------------------------------------
   // Pin action codes
   // ----------------------------------------
   localparam logic [3:0] ACT_LOW_LOW = 4'h1;
   localparam logic [3:0] ACT_LOW_HIGH = 4'h2;
   localparam logic [3:0] ACT_LOW_TGL = 4'h3;
   localparam logic [3:0] ACT_HIGH_LOW = 4'h5;
   localparam logic [3:0] ACT_HIGH_HIGH = 4'h6;
   localparam logic [3:0] ACT_HIGH_TGL = 4'h7;
   // ----------------------------------------
   // Reset values and timing
   // ----------------------------------------
   localparam logic [15:0] RST_PERIOD = 16'hFFFF;
   localparam logic [15:0] RST_DEAD = 16'h0001;
   localparam int CLK_MHZ = 100;
   localparam int TICK_MHZ = 25;
   localparam int TICK_DIV = CLK_MHZ / TICK_MHZ;
   localparam logic [1:0] AXI_OKAY = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      PWMTDC_IDLE = 2'b00,
      PWMTDC_RESP = 2'b01
   } pwmtdc_bus_e;
endpackage

// file: include/pwmtdc_phase_if.sv
// Purpose: Carries one phase's compare and count state to a dead-time unit.
// Assumes: Single clock domain.
// Notes: One instance per phase.
`timescale 1ns/1ps
`default_nettype none
interface pwmtdc_phase_if;
   logic [15:0] duty;
   logic [15:0] count;
   logic up;
   logic tick;
   logic run;
   logic [15:0] dead;
   logic pos;
   logic neg;
   modport core (output duty, output count, output up, output tick,
      output run, output dead, input pos, input neg);
   modport phase (input duty, input count, input up, input tick,
      input run, input dead, output pos, output neg);
endinterface
`default_nettype wire

// file: src/pwmtdc_phase.sv
// Purpose: One complementary phase with dead time.
// Assumes: Count ticks arrive as one-cycle enables.
// Notes: Outputs start low (inactive) and are active high.
`timescale 1ns/1ps
`default_nettype none
module pwmtdc_phase (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   pwmtdc_phase_if.phase p
);
   import pwmtdc_pkg::*;
   logic level_reg;
   logic pos_reg;
   logic neg_reg;
   logic [15:0] dt_reg;
   // ----------------------------------------
   // Compare level
   // ----------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         level_reg <= 1'b0;
      end else if (!p.run) begin
         level_reg <= 1'b0;
      end else if (p.tick && p.count == p.duty) begin
         level_reg <= p.up;
      end
   end
   // ----------------------------------------
   // Dead time: both off while counting down
   // ----------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         dt_reg <= 16'h0000;
         pos_reg <= 1'b0;
         neg_reg <= 1'b0;
      end else if (!p.run) begin
         dt_reg <= 16'h0000;
         pos_reg <= 1'b0;
         neg_reg <= 1'b0;
      end else if ((pos_reg != level_reg) || (neg_reg == level_reg)) begin
         if (pos_reg || neg_reg) begin
            pos_reg <= 1'b0;
            neg_reg <= 1'b0;
            dt_reg <= p.dead;
         end else if (dt_reg != 16'h0000) begin
            dt_reg <= dt_reg - 16'h0001;
         end else begin
            pos_reg <= level_reg;
            neg_reg <= !level_reg;
         end
      end
   end
   assign p.pos = pos_reg;
   assign p.neg = neg_reg;
   a_no_overlap: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      !(pos_reg && neg_reg))
      else $error("Both phase outputs active");
endmodule // pwmtdc_phase
`default_nettype wire

// file: src/pwmtdc_top.sv
// Purpose: PWM timer with single-output and complementary modes.
// Assumes: AXI4-Lite slave, one clock, count tick from a divider.
// Notes: Rules kept by this block are listed below.
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pwmtdc_top #(
   parameter int TICK_DIV_P = pwmtdc_pkg::TICK_DIV,
   parameter logic LOCKED_CHAN = 1'b0
) (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic o_pin_a,
   output logic o_pin_a_oe,
   output logic [2:0] o_phase_pos,
   output logic [2:0] o_phase_neg,
   output logic o_period_match
);
   import pwmtdc_pkg::*;
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [3:0] ctrl_reg;
   logic [7:0] output_action_reg;
   logic [15:0] duty_compare_a_reg;
   logic [15:0] period_compare_b_reg;
   logic [15:0] buffer_compare_c_reg;
   logic rw_enable_reg_a_reg;
   logic rw_enable_reg_b_reg;
   logic [15:0] buf_reg [3];
   logic [15:0] tmp_reg [3];
   logic [15:0] cmp_reg [3];
   logic [15:0] dead_reg;
   logic [15:0] timer_count_value_reg;
   logic up_reg;
   logic pin_reg;
   logic [7:0] div_reg;
   logic tick;
   logic wr_en;
   logic rd_en;
   logic bvalid_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic bresp_err_reg;
   logic rresp_err_reg;
   logic period_hit;
   logic duty_hit;
   logic overflow;
   logic underflow;
   logic action_ok;
   logic [3:0] code_a;
   logic [3:0] code_b;
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'b00) && (a <= OFF_COUNT);
   endfunction
   function automatic logic [3:0] action_lsb(input logic [7:0] v,
      input int lsb);
      action_lsb = v[lsb +: 4];
   endfunction
   function automatic logic apply(input logic [3:0] c, input logic cur);
      case (c)
         ACT_LOW_LOW, ACT_HIGH_LOW: apply = 1'b0;
         ACT_LOW_HIGH, ACT_HIGH_HIGH: apply = 1'b1;
         ACT_LOW_TGL, ACT_HIGH_TGL: apply = !cur;
         default: apply = cur;
      endcase
   endfunction
   // ----------------------------------------
   // Bus handshake
   // ----------------------------------------
   assign wr_en = i_awvalid && i_wvalid && !bvalid_reg;
   assign rd_en = i_arvalid && !rvalid_reg;
   assign o_awready = wr_en;
   assign o_wready = wr_en;
   assign o_arready = rd_en;
   assign o_bvalid = bvalid_reg;
   assign o_rvalid = rvalid_reg;
   assign o_bresp = bresp_err_reg ? AXI_SLVERR : AXI_OKAY;
   assign o_rresp = rresp_err_reg ? AXI_SLVERR : AXI_OKAY;
   assign o_rdata = rdata_reg;
   // Locked channels need both unlock bits
   assign action_ok = !LOCKED_CHAN ||
      (rw_enable_reg_a_reg && rw_enable_reg_b_reg);
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         bvalid_reg <= 1'b0;
         bresp_err_reg <= 1'b0;
      end else if (wr_en) begin
         bvalid_reg <= 1'b1;
         bresp_err_reg <= !mapped(i_awaddr);
      end else if (i_bready) begin
         bvalid_reg <= 1'b0;
      end
   end
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         rvalid_reg <= 1'b0;
         rresp_err_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else if (rd_en) begin
         rvalid_reg <= 1'b1;
         rresp_err_reg <= !mapped(i_araddr);
         case (i_araddr)
            OFF_CTRL: rdata_reg <= {27'h0, LOCKED_CHAN, ctrl_reg};
            OFF_ACTION: rdata_reg <= {24'h0, output_action_reg};
            OFF_DUTY_A: rdata_reg <= {16'h0, duty_compare_a_reg};
            OFF_PERIOD_B: rdata_reg <= {16'h0, period_compare_b_reg};
            OFF_BUF_C: rdata_reg <= {16'h0, buffer_compare_c_reg};
            OFF_RWE_A: rdata_reg <= {31'h0, rw_enable_reg_a_reg};
            OFF_RWE_B: rdata_reg <= {31'h0, rw_enable_reg_b_reg};
            OFF_CDUTY_U: rdata_reg <= {16'h0, buf_reg[0]};
            OFF_CDUTY_V: rdata_reg <= {16'h0, buf_reg[1]};
            OFF_CDUTY_W: rdata_reg <= {16'h0, buf_reg[2]};
            OFF_DEAD: rdata_reg <= {16'h0, dead_reg};
            OFF_STATUS: rdata_reg <= {29'h0, up_reg, pin_reg, action_ok};
            OFF_COUNT: rdata_reg <= {16'h0, timer_count_value_reg};
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end else if (i_rready) begin
         rvalid_reg <= 1'b0;
      end
   end
   // ----------------------------------------
   // Software-written configuration
   // ----------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_reg <= 4'h0;
         output_action_reg <= 8'h00;
         period_compare_b_reg <= RST_PERIOD;
         buffer_compare_c_reg <= RST_PERIOD;
         rw_enable_reg_a_reg <= 1'b0;
         rw_enable_reg_b_reg <= 1'b0;
         dead_reg <= RST_DEAD;
         buf_reg <= '{default: 16'h0000};
      end else if (wr_en && i_wstrb[0]) begin
         case (i_awaddr)
            OFF_CTRL: ctrl_reg <= i_wdata[3:0];
            OFF_ACTION: if (action_ok) output_action_reg <= i_wdata[7:0];
            OFF_PERIOD_B: period_compare_b_reg <= i_wdata[15:0];
            OFF_BUF_C: buffer_compare_c_reg <= i_wdata[15:0];
            OFF_RWE_A: rw_enable_reg_a_reg <= i_wdata[RWE_BIT];
            OFF_RWE_B: rw_enable_reg_b_reg <= i_wdata[RWE_BIT];
            OFF_CDUTY_U: buf_reg[0] <= i_wdata[15:0];
            OFF_CDUTY_V: buf_reg[1] <= i_wdata[15:0];
            OFF_CDUTY_W: buf_reg[2] <= i_wdata[15:0];
            OFF_DEAD: dead_reg <= i_wdata[15:0];
            default: ;
         endcase
      end
   end
   // ----------------------------------------
   // Tick divider and counter
   // ----------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         div_reg <= 8'h00;
      end else if (div_reg == 8'(TICK_DIV_P - 1)) begin
         div_reg <= 8'h00;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end
   assign tick = ctrl_reg[CTRL_RUN] && (div_reg == 8'(TICK_DIV_P - 1));
   assign period_hit = tick && up_reg &&
      (timer_count_value_reg == period_compare_b_reg);
   // Counter clears first, so a larger duty never matches
   assign duty_hit = tick && !ctrl_reg[CTRL_COMP] &&
      (timer_count_value_reg == duty_compare_a_reg);
   assign overflow = period_hit && ctrl_reg[CTRL_COMP];
   assign underflow = tick && !up_reg && (timer_count_value_reg == 16'h0001);
   assign o_period_match = period_hit;
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         timer_count_value_reg <= 16'h0000;
         up_reg <= 1'b1;
      end else if (!ctrl_reg[CTRL_RUN]) begin
         timer_count_value_reg <= 16'h0000;
         up_reg <= 1'b1;
      end else if (tick) begin
         if (!ctrl_reg[CTRL_COMP]) begin
            up_reg <= 1'b1;
            timer_count_value_reg <= period_hit ? 16'h0000
               : timer_count_value_reg + 16'h0001;
         end else if (period_hit) begin
            up_reg <= 1'b0;
            timer_count_value_reg <= timer_count_value_reg - 16'h0001;
         end else if (underflow) begin
            up_reg <= 1'b1;
            timer_count_value_reg <= 16'h0000;
         end else begin
            timer_count_value_reg <= up_reg ? timer_count_value_reg + 16'h0001
               : timer_count_value_reg - 16'h0001;
         end
      end
   end
   // ----------------------------------------
   // Duty register, buffer transfer
   // ----------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         duty_compare_a_reg <= RST_PERIOD;
      end else if (wr_en && i_wstrb[0] && i_awaddr == OFF_DUTY_A) begin
         duty_compare_a_reg <= i_wdata[15:0];
      end else if (duty_hit && ctrl_reg[CTRL_BUF_EN]) begin
         // Old buffer content wins over a same-cycle buffer write
         duty_compare_a_reg <= buffer_compare_c_reg;
      end
   end
   // ----------------------------------------
   // Single-output pin and channel pin A
   // ----------------------------------------
   assign code_a = action_lsb(output_action_reg, ACT_A_LSB);
   assign code_b = action_lsb(output_action_reg, ACT_B_LSB);
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         pin_reg <= 1'b0;
      end else if (!ctrl_reg[CTRL_RUN]) begin
         // Initial level follows the A code before counting
         pin_reg <= code_a[2];
      end else if (ctrl_reg[CTRL_COMP]) begin
         if (period_hit) pin_reg <= !pin_reg;
      end else if (period_hit && duty_hit) begin
         pin_reg <= pin_reg;
      end else if (period_hit) begin
         pin_reg <= apply(code_b, pin_reg);
      end else if (duty_hit) begin
         // Duty zero matches one tick after the clear
         pin_reg <= apply(code_a, pin_reg);
      end
   end
   assign o_pin_a = ctrl_reg[CTRL_PINSEL] && pin_reg;
   assign o_pin_a_oe = ctrl_reg[CTRL_PINSEL];
   // ----------------------------------------
   // Complementary phases
   // ----------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         tmp_reg <= '{default: 16'h0000};
         cmp_reg <= '{default: 16'h0000};
      end else begin
         if (overflow) tmp_reg <= buf_reg;
         if (underflow) cmp_reg <= tmp_reg;
      end
   end
   generate
      for (genvar g = 0; g < 3; g++) begin : g_phase
         pwmtdc_phase_if pif ();
         assign pif.duty = cmp_reg[g];
         assign pif.count = timer_count_value_reg;
         assign pif.up = up_reg;
         assign pif.tick = tick;
         assign pif.run = ctrl_reg[CTRL_RUN] && ctrl_reg[CTRL_COMP];
         assign pif.dead = dead_reg;
         pwmtdc_phase u_phase (
            .i_clk_sys(i_clk_sys),
            .i_nrst(i_nrst),
            .p(pif.phase)
         );
         assign o_phase_pos[g] = pif.pos;
         assign o_phase_neg[g] = pif.neg;
      end
   endgenerate
   a_count_clear: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (period_hit && !ctrl_reg[CTRL_COMP]) |=> timer_count_value_reg == 0)
      else $error("Counter not cleared on period match");
   a_lock_hold: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (wr_en && i_awaddr == OFF_ACTION && !action_ok) |=>
      $stable(output_action_reg))
      else $error("Locked action register changed");
   a_buf_xfer: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (duty_hit && ctrl_reg[CTRL_BUF_EN] && !(wr_en && i_awaddr == OFF_DUTY_A))
      |=> duty_compare_a_reg == $past(buffer_compare_c_reg))
      else $error("Buffer transfer wrong");
   a_pb_action: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (period_hit && !duty_hit && !ctrl_reg[CTRL_COMP]
      && code_b == ACT_HIGH_LOW) |=> !pin_reg)
      else $error("Period action low not applied");
   a_same_match: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (period_hit && duty_hit) |=> $stable(pin_reg))
      else $error("Pin changed on double match");
   a_comp_toggle: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (period_hit && ctrl_reg[CTRL_COMP] && ctrl_reg[CTRL_RUN])
      |=> pin_reg != $past(pin_reg))
      else $error("Pin did not toggle");
   a_tmp_cmp: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      underflow |=> cmp_reg[0] == $past(tmp_reg[0]))
      else $error("Temporary not moved at trough");
   a_no_match: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (duty_compare_a_reg > period_compare_b_reg && !ctrl_reg[CTRL_COMP]
      && timer_count_value_reg <= period_compare_b_reg) |-> !duty_hit)
      else $error("Duty match above period");
endmodule // pwmtdc_top
`default_nettype wire

// file: sim/pwmtdc_load.sv
// Purpose: Load model on the bridge pins; counts shoot-through.
// Assumes: Pins are sampled on the system clock.
// Notes: A short is counted, not corrected, so the bench can judge it.
`timescale 1ns/1ps
`default_nettype none
module pwmtdc_load (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic [2:0] i_pos,
   input wire logic [2:0] i_neg,
   output var int o_short_cnt,
   output var logic [2:0] o_pos_seen
);
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_short_cnt <= 0;
         o_pos_seen <= 3'h0;
      end else begin
         if ((i_pos & i_neg) !== 3'h0) begin
            o_short_cnt <= o_short_cnt + 1;
         end
         o_pos_seen <= o_pos_seen | i_pos;
      end
   end
endmodule // pwmtdc_load
`default_nettype wire

// file: sim/pwm_timer_duty_edge_control_tb_top.sv
// Purpose: Self-checking bench for the PWM timer block.
// Assumes: Tick divider 1 and a locked channel, so period 9 is 10 clocks.
// Notes: Pin levels are sampled on the falling edge, away from updates.
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_duty_edge_control_tb_top;
   import pwmtdc_pkg::*;
   typedef struct {
      logic [7:0] a;
      logic wr;
      logic [15:0] d;
      logic [1:0] r;
   } pwmtdc_row_s;
   logic i_clk_sys = 1'b0, i_nrst = 1'b0;
   logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic [3:0] i_wstrb = 4'hF;
   logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
   logic i_arvalid = 1'b0, i_rready = 1'b0;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0] o_bresp, o_rresp, rsp;
   logic [31:0] o_rdata, rd;
   logic o_pin_a, o_pin_a_oe, o_period_match;
   logic [2:0] o_phase_pos, o_phase_neg, pos_seen;
   int short_cnt, fail_count = 0, num_checks = 0, hi, tog, pm, n;
   pwmtdc_row_s rows[8] = '{
      '{OFF_PERIOD_B, 1'b0, 16'hFFFF, AXI_OKAY},
      '{OFF_DUTY_A, 1'b0, 16'hFFFF, AXI_OKAY},
      '{OFF_BUF_C, 1'b0, 16'hFFFF, AXI_OKAY},
      '{OFF_DEAD, 1'b0, 16'h0001, AXI_OKAY},
      '{8'h3C, 1'b0, 16'h0000, AXI_SLVERR},
      '{8'h40, 1'b1, 16'h0005, AXI_SLVERR},
      '{OFF_PERIOD_B, 1'b1, 16'h0009, AXI_OKAY},
      '{OFF_PERIOD_B, 1'b0, 16'h0009, AXI_OKAY}};

   always #5 i_clk_sys = ~i_clk_sys;

   pwmtdc_top #(.TICK_DIV_P(1), .LOCKED_CHAN(1'b1)) DUT (
      .i_clk_sys, .i_nrst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
      .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
      .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
      .i_rready, .o_pin_a, .o_pin_a_oe, .o_phase_pos, .o_phase_neg,
      .o_period_match);
   pwmtdc_load load_u (.i_clk_sys, .i_nrst, .i_pos(o_phase_pos),
      .i_neg(o_phase_neg), .o_short_cnt(short_cnt), .o_pos_seen(pos_seen));

   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string s, input logic [31:0] e,
      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("[FAIL] %s expected %0h seen %0h", s, e, g);
         fail_count++;
      end
   endtask

   task automatic tmo(input int k);
      if (k >= 50) begin
         $display("[FAIL] handshake expected within 50 seen %0d", k);
         fail_count++;
         complete_run();
      end
   endtask

   // ----------------------------------------
   // Bus master; valid held until ready seen
   // ----------------------------------------
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      int k;
      // Start on a rising edge, so back-to-back calls never drive twice at once
      @(posedge i_clk_sys);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      @(negedge i_clk_sys);
      for (k = 0; k < 50 && !(o_awready && o_wready); k++) @(negedge i_clk_sys);
      tmo(k);
      @(posedge i_clk_sys);
      i_awvalid <= 1'b0;
      i_wvalid <= 1'b0;
      @(negedge i_clk_sys);
      for (k = 0; k < 50 && !o_bvalid; k++) @(negedge i_clk_sys);
      tmo(k);
      r = o_bresp;
      @(posedge i_clk_sys);
      i_bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      int k;
      @(posedge i_clk_sys);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      @(negedge i_clk_sys);
      for (k = 0; k < 50 && !o_arready; k++) @(negedge i_clk_sys);
      tmo(k);
      @(posedge i_clk_sys);
      i_arvalid <= 1'b0;
      @(negedge i_clk_sys);
      for (k = 0; k < 50 && !o_rvalid; k++) @(negedge i_clk_sys);
      tmo(k);
      d = o_rdata;
      r = o_rresp;
      @(posedge i_clk_sys);
      i_rready <= 1'b0;
   endtask

   // Counts high samples, pin edges and period pulses over k clocks
   task automatic watch(input int k);
      logic p;
      @(negedge i_clk_sys);
      p = o_pin_a;
      hi = 0;
      tog = 0;
      pm = 0;
      repeat (k) begin
         @(negedge i_clk_sys);
         hi += int'(o_pin_a === 1'b1);
         tog += int'(o_pin_a !== p);
         pm += int'(o_period_match === 1'b1);
         p = o_pin_a;
      end
   endtask

   // Waits for the next period pulse, sampled on falling edges
   task automatic wait_pm;
      int k;
      @(negedge i_clk_sys);
      for (k = 0; k < 50 && o_period_match !== 1'b1; k++) begin
         @(negedge i_clk_sys);
      end
      tmo(k);
   endtask

   initial begin
      repeat (2) @(posedge i_clk_sys);
      chk("oe_rst", 0, o_pin_a_oe);
      chk("pos_rst", 0, {o_phase_pos, o_phase_neg});
      i_nrst <= 1'b1;
      @(posedge i_clk_sys);
      foreach (rows[k]) begin
         if (rows[k].wr) axw(rows[k].a, {16'h0, rows[k].d}, rsp);
         else axr(rows[k].a, rd, rsp);
         chk("resp", rows[k].r, rsp);
         if (!rows[k].wr && rows[k].r == AXI_OKAY) begin
            chk("rdata", rows[k].d, rd[15:0]);
         end
      end
      axr(OFF_CTRL, rd, rsp);
      chk("locked", 1, rd[CTRL_LOCKED]);
      axw(OFF_ACTION, 32'h56, rsp);
      axr(OFF_ACTION, rd, rsp);
      chk("act_lock", 0, rd[7:0] == 8'h56);
      axw(OFF_RWE_A, 32'h1, rsp);
      axw(OFF_ACTION, 32'h56, rsp);
      axr(OFF_ACTION, rd, rsp);
      chk("act_half", 0, rd[7:0] == 8'h56);
      axw(OFF_RWE_B, 32'h1, rsp);
      axw(OFF_ACTION, 32'h56, rsp);
      axr(OFF_ACTION, rd, rsp);
      chk("act_open", 32'h56, rd[7:0]);
      axw(OFF_CTRL, 32'h8, rsp);
      @(negedge i_clk_sys);
      chk("oe", 1, o_pin_a_oe);
      chk("init_hi", 1, o_pin_a);
      axw(OFF_DUTY_A, 32'h9, rsp);
      axw(OFF_CTRL, 32'h9, rsp);
      watch(30);
      chk("full", 30, hi);
      wait_pm();
      @(negedge i_clk_sys);
      for (n = 1; n < 50 && !o_period_match; n++) @(negedge i_clk_sys);
      tmo(n);
      chk("period", 10, n);
      axr(OFF_COUNT, rd, rsp);
      chk("cnt_le", 1, rd[15:0] <= 16'h0009);
      // Unbuffered duty past the period: no duty match, pin falls
      axw(OFF_DUTY_A, 32'hC, rsp);
      watch(20);
      watch(20);
      chk("zero", 0, hi);
      axw(OFF_ACTION, 32'h66, rsp);
      watch(20);
      watch(20);
      chk("b_high", 20, hi);
      axw(OFF_DUTY_A, 32'h9, rsp);
      axw(OFF_BUF_C, 32'h9, rsp);
      axw(OFF_CTRL, 32'hB, rsp);
      axw(OFF_ACTION, 32'h56, rsp);
      watch(20);
      watch(10);
      chk("buf_full", 10, hi);
      // Buffer written early in a period: the next match still holds high
      wait_pm();
      axw(OFF_BUF_C, 32'hC, rsp);
      wait_pm();
      @(negedge i_clk_sys);
      chk("late_hold", 1, o_pin_a);
      wait_pm();
      @(negedge i_clk_sys);
      chk("late_drop", 0, o_pin_a);
      watch(20);
      watch(20);
      chk("buf_zero", 0, hi);
      // Leaving 0% needs the duty written directly
      axw(OFF_BUF_C, 32'h4, rsp);
      axw(OFF_DUTY_A, 32'h4, rsp);
      axw(OFF_ACTION, 32'h52, rsp);
      watch(20);
      watch(20);
      chk("pwm", 10, hi);
      axw(OFF_CDUTY_U, 32'h3, rsp);
      axw(OFF_CDUTY_V, 32'h5, rsp);
      axw(OFF_CDUTY_W, 32'h7, rsp);
      axw(OFF_PERIOD_B, 32'h9, rsp);
      axw(OFF_CTRL, 32'hD, rsp);
      watch(100);
      watch(200);
      chk("short", 0, short_cnt);
      chk("phases", 3'h7, pos_seen);
      chk("toggle", 1, tog + 1 >= pm && tog <= pm + 1 && pm > 0);
      complete_run();
   end
endmodule // pwm_timer_duty_edge_control_tb_top
`default_nettype wire
